//--- verilog/sms_map.svh
// Register offsets, field positions, reset values and timing counts of the start sequencer
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH

// Register byte offsets (only haddr[7:0] is decoded)
`define SMS_CTRL_OFS 8'h00
`define SMS_WINDOW_OFS 8'h04
`define SMS_BANK_OFS 8'h08
`define SMS_STATUS_OFS 8'h0C
`define SMS_OFFTIME_OFS 8'h10

// Control register fields
`define SMS_CTRL_MODE_LSB 0
`define SMS_CTRL_RESTART_BIT 2
`define SMS_CTRL_HOT_CMD_BIT 3
`define SMS_CTRL_COLD_CMD_BIT 4

// Start mode codes
`define SMS_MODE_TIMED 2'h0
`define SMS_MODE_HOT 2'h1
`define SMS_MODE_COLD 2'h2
`define SMS_MODE_HOST 2'h3

// Product lines: line A defaults to plain hot start, line B to timed hot start
`define SMS_LINE_A 1'h0
`define SMS_LINE_B 1'h1

// Reset values and limits
`define SMS_WINDOW_RESET 12'h000
`define SMS_WINDOW_MAX 12'hE10
`define SMS_BANK_RESET 4'h0
`define SMS_BANK_MAX 4'hC

// Timing: clock rate, time base period and the long power-off limit
`define SMS_CLK_HZ 32'h05F5E100
`define SMS_TICK_PERIOD_S 32'h00000001
`define SMS_LONG_OFF_HOURS 32'h00000018
`define SMS_LONG_OFF_S (`SMS_LONG_OFF_HOURS * 32'h00000E10)

`endif

//--- verilog/sms_pkg.sv
// Types shared by the start sequencer modules
package sms_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_EVAL = 3'b000,
        ST_HOST = 3'b001,
        ST_CLEAR = 3'b010,
        ST_FLASH = 3'b011,
        ST_HMI = 3'b100,
        ST_RUN = 3'b101
    } sms_state_t;

    // Kind of start chosen
    typedef enum logic [1:0] {
        SK_HOT = 2'b00,
        SK_COLD_FULL = 2'b01,
        SK_COLD_KEEP = 2'b10
    } sms_kind_t;

    // Indications toward the loop logic and the front panel
    typedef struct packed {
        logic execution_indicator;
        logic run_start_indication;
        logic cold_start_active_flag;
        logic access_enable;
        logic cold_init;
    } sms_ind_t;

endpackage : sms_pkg

//--- verilog/sms_tick.sv
// One-second time base for the retained alive stamp
`timescale 1ns/1ps
module sms_tick
#(
    parameter int unsigned TICK_CYCLES = 100
)
(
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);

    logic [31:0] count;

    // Free-running divider; tick is one cycle wide
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count <= 32'h00000000;
            tick <= 1'b0;
        end
        else if (count == 32'(TICK_CYCLES - 1))
        begin
            count <= 32'h00000000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 32'h00000001;
            tick <= 1'b0;
        end
    end

endmodule : sms_tick

//--- verilog/sms_xfer.sv
// Request/done handshake for one reload transfer
`timescale 1ns/1ps
module sms_xfer
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic abort,
    input wire logic done,
    output logic req,
    output logic finished
);

    // Request stands from start until done; an abort drops it at once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            req <= 1'b0;
        end
        else if (abort || (req && done))
        begin
            req <= 1'b0;
        end
        else if (start)
        begin
            req <= 1'b1;
        end
    end

    // One-cycle completion pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            finished <= 1'b0;
        end
        else
        begin
            finished <= req && done && !abort;
        end
    end

endmodule : sms_xfer

//--- verilog/sms_startup.sv
// Startup mode sequencer with AHB-Lite register slave
// What this block does
// - Four start-mode codes: timed, hot, cold, host
// - Evaluate at power-up and restart rising edge
// - Default mode depends on product line
// - Hot start resumes with all values kept
// - Execution indicator lights as run begins
// - Off over 24 hours forces cold start, except in host mode
// - Forced cold: manual, MV zero, local setpoint
// - Cold start clears memory, MV, switches first
// - Normal cold reloads flash, then host data
// - Timed mode: hot if within window
// - Timed mode: cold if window exceeded
// - Window-exceeded cold start skips all reloads
// - One line: long-off timed cold fully reloads
// - Host mode: hot or cold command bit
// - Host mode: refuse access until command bit
// - Expose run-start and cold-start-active flags
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sms_map.svh"
module sms_startup
#(
    parameter logic PRODUCT_LINE = `SMS_LINE_A,
    parameter int unsigned TICK_CYCLES = `SMS_CLK_HZ * `SMS_TICK_PERIOD_S
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [31:0] rtc_seconds,
    input wire logic [31:0] last_alive_seconds,
    output logic [31:0] alive_stamp,
    input wire logic [1:0] load_done,
    output logic [1:0] load_req,
    output logic [3:0] hmi_bank_select,
    output sms_pkg::sms_ind_t ind
);

    // Mode reset value follows the product line
    localparam logic [1:0] MODE_RESET =
        (PRODUCT_LINE == `SMS_LINE_A) ? `SMS_MODE_HOT : `SMS_MODE_TIMED;

    sms_pkg::sms_state_t state;
    sms_pkg::sms_state_t next_state;
    sms_pkg::sms_kind_t kind;
    sms_pkg::sms_kind_t kind_q;

    logic [1:0] start_mode_select;
    logic restart_request_bit;
    logic host_hot_start_cmd;
    logic host_cold_start_cmd;
    logic [11:0] hot_start_window_seconds;
    logic restart_prev;
    logic restart_edge;
    logic [31:0] off_seconds;
    logic long_off;
    logic in_window;
    logic go_run;
    logic [1:0] xfer_start;
    logic [1:0] xfer_fin;
    logic tick;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_valid;
    logic [31:0] read_mux;
    logic [7:0] status_word;
    logic execution_indicator;
    logic run_start_indication;
    logic cold_start_active_flag;
    logic access_enable;
    logic cold_init;

    // Each indication has its own flip-flop, so the struct has a single driver
    assign ind = '{execution_indicator, run_start_indication, cold_start_active_flag,
                   access_enable, cold_init};

    // Zero-wait slave that always answers OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign addr_valid = hsel && hready && htrans[1];

    // Capture the write address phase; data lands one cycle later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else
        begin
            wr_pend <= addr_valid && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Status word: state, panel flags and the start kind chosen
    assign status_word = {kind_q, access_enable, cold_start_active_flag,
                          execution_indicator, state};

    // Read multiplexer; unmapped offsets read as zero
    always_comb
    begin
        read_mux = 32'h00000000;
        unique case (haddr[7:0])
            `SMS_CTRL_OFS: read_mux = {27'h0000000, host_cold_start_cmd,
                                       host_hot_start_cmd, restart_request_bit,
                                       start_mode_select};
            `SMS_WINDOW_OFS: read_mux = {20'h00000, hot_start_window_seconds};
            `SMS_BANK_OFS: read_mux = {28'h0000000, hmi_bank_select};
            `SMS_STATUS_OFS: read_mux = {24'h000000, status_word};
            `SMS_OFFTIME_OFS: read_mux = off_seconds;
            default: read_mux = 32'h00000000;
        endcase
    end

    // Read data is registered at the address phase and stands in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
        end
        else if (addr_valid && !hwrite)
        begin
            hrdata <= read_mux;
        end
    end

    // Control register: mode, restart request and host start commands
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_mode_select <= MODE_RESET;
            restart_request_bit <= 1'b0;
            host_hot_start_cmd <= 1'b0;
            host_cold_start_cmd <= 1'b0;
        end
        else if (wr_pend && wr_addr == `SMS_CTRL_OFS)
        begin
            start_mode_select <= hwdata[`SMS_CTRL_MODE_LSB +: 2];
            restart_request_bit <= hwdata[`SMS_CTRL_RESTART_BIT];
            host_hot_start_cmd <= hwdata[`SMS_CTRL_HOT_CMD_BIT];
            host_cold_start_cmd <= hwdata[`SMS_CTRL_COLD_CMD_BIT];
        end
    end

    // Hot-start window; writes above the maximum are clamped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hot_start_window_seconds <= `SMS_WINDOW_RESET;
        end
        else if (wr_pend && wr_addr == `SMS_WINDOW_OFS)
        begin
            if (hwdata[31:0] > {20'h00000, `SMS_WINDOW_MAX})
            begin
                hot_start_window_seconds <= `SMS_WINDOW_MAX;
            end
            else
            begin
                hot_start_window_seconds <= hwdata[11:0];
            end
        end
    end

    // Host data bank; the host keeps it in range, larger codes are dropped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hmi_bank_select <= `SMS_BANK_RESET;
        end
        else if (wr_pend && wr_addr == `SMS_BANK_OFS && hwdata[31:0] <= 32'h0000000C)
        begin
            hmi_bank_select <= hwdata[3:0];
        end
    end

    // Restart request edge; only an off-to-on change restarts
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            restart_prev <= 1'b0;
        end
        else
        begin
            restart_prev <= restart_request_bit;
        end
    end

    assign restart_edge = restart_request_bit && !restart_prev;

    // Retained time base: stamp refreshed each second while running
    sms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    // Stamp is only refreshed in run, so a stopped device ages like a powered-off one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            alive_stamp <= 32'h00000000;
        end
        else if (tick && state == sms_pkg::ST_RUN)
        begin
            alive_stamp <= rtc_seconds;
        end
    end

    // Power-off duration against the window and the long-off limit
    assign off_seconds = rtc_seconds - last_alive_seconds;
    assign long_off = off_seconds > `SMS_LONG_OFF_S;
    assign in_window = off_seconds <= {20'h00000, hot_start_window_seconds};

    // Start kind chosen from the mode, the off time and the host commands
    always_comb
    begin
        kind = sms_pkg::SK_HOT;
        unique case (start_mode_select)
            `SMS_MODE_TIMED:
            begin
                if (in_window)
                begin
                    kind = sms_pkg::SK_HOT;
                end
                else if (long_off && PRODUCT_LINE == `SMS_LINE_A)
                begin
                    kind = sms_pkg::SK_COLD_FULL;
                end
                else
                begin
                    kind = sms_pkg::SK_COLD_KEEP;
                end
            end
            `SMS_MODE_HOT:
            begin
                kind = long_off ? sms_pkg::SK_COLD_FULL : sms_pkg::SK_HOT;
            end
            `SMS_MODE_COLD:
            begin
                kind = sms_pkg::SK_COLD_FULL;
            end
            `SMS_MODE_HOST:
            begin
                kind = host_cold_start_cmd ? sms_pkg::SK_COLD_FULL : sms_pkg::SK_HOT;
            end
        endcase
    end

    // Sequencer transitions; a restart edge overrides any state
    always_comb
    begin
        next_state = state;
        if (restart_edge)
        begin
            next_state = sms_pkg::ST_EVAL;
        end
        else
        begin
            unique case (state)
                sms_pkg::ST_EVAL:
                begin
                    if (start_mode_select == `SMS_MODE_HOST)
                    begin
                        next_state = sms_pkg::ST_HOST;
                    end
                    else if (kind == sms_pkg::SK_HOT)
                    begin
                        next_state = sms_pkg::ST_RUN;
                    end
                    else
                    begin
                        next_state = sms_pkg::ST_CLEAR;
                    end
                end
                sms_pkg::ST_HOST:
                begin
                    if (host_hot_start_cmd || host_cold_start_cmd)
                    begin
                        next_state = (kind == sms_pkg::SK_HOT) ? sms_pkg::ST_RUN
                                                               : sms_pkg::ST_CLEAR;
                    end
                end
                sms_pkg::ST_CLEAR:
                begin
                    next_state = (kind_q == sms_pkg::SK_COLD_FULL) ? sms_pkg::ST_FLASH
                                                                   : sms_pkg::ST_RUN;
                end
                sms_pkg::ST_FLASH:
                begin
                    if (xfer_fin[0])
                    begin
                        next_state = sms_pkg::ST_HMI;
                    end
                end
                sms_pkg::ST_HMI:
                begin
                    if (xfer_fin[1])
                    begin
                        next_state = sms_pkg::ST_RUN;
                    end
                end
                sms_pkg::ST_RUN:
                begin
                    next_state = sms_pkg::ST_RUN;
                end
                default:
                begin
                    next_state = sms_pkg::ST_EVAL;
                end
            endcase
        end
    end

    // State register; power-up always begins with an evaluation
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= sms_pkg::ST_EVAL;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Start kind is frozen when the decision leaves evaluation or the host wait
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kind_q <= sms_pkg::SK_HOT;
        end
        else if ((state == sms_pkg::ST_EVAL || state == sms_pkg::ST_HOST)
                 && next_state != state && !restart_edge)
        begin
            kind_q <= kind;
        end
    end

    assign go_run = next_state == sms_pkg::ST_RUN && state != sms_pkg::ST_RUN;

    // Reload starts: flash first, host data only after flash has finished
    assign xfer_start[0] = state == sms_pkg::ST_CLEAR && next_state == sms_pkg::ST_FLASH;
    assign xfer_start[1] = state == sms_pkg::ST_FLASH && next_state == sms_pkg::ST_HMI;

    // Flash reload (channel 0) and host data reload (channel 1)
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_xfer
            sms_xfer u_xfer (
                .hclk(hclk),
                .hresetn(hresetn),
                .start(xfer_start[ch]),
                .abort(restart_edge),
                .done(load_done[ch]),
                .req(load_req[ch]),
                .finished(xfer_fin[ch])
            );
        end
    endgenerate

    // Cold init pulse stands for the one clear cycle: memory, MV 0%, manual, local
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cold_init <= 1'b0;
        end
        else
        begin
            cold_init <= next_state == sms_pkg::ST_CLEAR
                             && state != sms_pkg::ST_CLEAR;
        end
    end

    // Execution indicator rises with the run-start pulse, drops on restart
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            execution_indicator <= 1'b0;
            run_start_indication <= 1'b0;
        end
        else
        begin
            run_start_indication <= go_run;
            if (restart_edge)
            begin
                execution_indicator <= 1'b0;
            end
            else if (go_run)
            begin
                execution_indicator <= 1'b1;
            end
        end
    end

    // Cold flag overlaps the run-start pulse so sequencing can switch loops to auto
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cold_start_active_flag <= 1'b0;
        end
        else if (next_state == sms_pkg::ST_CLEAR && state != sms_pkg::ST_CLEAR)
        begin
            cold_start_active_flag <= 1'b1;
        end
        else if (run_start_indication || restart_edge)
        begin
            cold_start_active_flag <= 1'b0;
        end
    end

    // Tool access and host exchange held off while waiting for a host command
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            access_enable <= 1'b0;
        end
        else
        begin
            access_enable <= next_state != sms_pkg::ST_HOST
                                 && next_state != sms_pkg::ST_EVAL;
        end
    end

endmodule : sms_startup

//--- verif/sms_startup_checker.sv
// Port-level assertions for the start sequencer
`timescale 1ns/1ps
module sms_startup_checker
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic [1:0] load_done,
    input wire logic [1:0] load_req,
    input wire logic [3:0] hmi_bank_select,
    input wire sms_pkg::sms_ind_t ind
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // The slave never stretches a transfer once out of reset
    a_ready_zero_wait:
        assert property ($past(hresetn) |-> hreadyout)
        else $error("hreadyout low after reset");
    // Indicator lights in the very cycle the run starts
    a_execution_indicator_with_run:
        assert property ($rose(ind.execution_indicator) |-> ind.run_start_indication)
        else $error("execution_indicator rose without run start");
    // A started run keeps its indicator for a few cycles at least
    a_execution_indicator_holds_run:
        assert property (ind.run_start_indication |-> ind.execution_indicator [*3])
        else $error("execution_indicator did not hold after run start");
    // Clearing happens before anything runs
    a_clear_before_run:
        assert property (ind.cold_init |-> ind.cold_start_active_flag && !ind.execution_indicator)
        else $error("cold init outside cold sequence");
    // Flash reload only follows the clear pulse
    a_flash_after_clear:
        assert property ($rose(load_req[0]) |-> $past(ind.cold_init))
        else $error("flash reload without clear");
    // Host data reload never overlaps the flash reload
    a_hmi_after_flash:
        assert property ($rose(load_req[1]) |-> !load_req[0])
        else $error("host reload overlaps flash reload");
    // Without a restart abort, the flash request is withdrawn only once its reload is done
    a_req_until_done:
        assert property ($fell(load_req[0]) |-> $past(load_done[0]))
        else $error("flash request dropped early");
    // No run while host access is still refused
    a_run_needs_access:
        assert property (ind.run_start_indication |-> ind.access_enable)
        else $error("run start with access refused");
    // Cold flag overlaps the run pulse one cycle, then clears
    a_flag_ends_run:
        assert property (ind.cold_start_active_flag && ind.run_start_indication
            |=> !ind.cold_start_active_flag)
        else $error("cold flag stayed after run start");
    // Bank output stays within the legal range
    a_bank_in_range:
        assert property (hmi_bank_select <= 4'hC)
        else $error("bank select out of range");

    c_cold_clear: cover property (ind.cold_init);
    c_hmi_reload: cover property ($rose(load_req[1]));
    c_hot_run: cover property (ind.run_start_indication && !ind.cold_start_active_flag);
endmodule : sms_startup_checker

bind sms_startup sms_startup_checker chk_u
(
    .hclk(hclk),
    .hresetn(hresetn),
    .hreadyout(hreadyout),
    .load_done(load_done),
    .load_req(load_req),
    .hmi_bank_select(hmi_bank_select),
    .ind(ind)
);

//--- verif/sms_host_model.sv
// Far-side model answering the flash and host data reload requests
`timescale 1ns/1ps
module sms_host_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] load_req,
    input wire logic [3:0] lat,
    output logic [1:0] load_done
);
    logic [3:0] cnt [2];

    // Done comes lat+1 cycles after a request rises; it falls once the request is gone
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt <= '{4'h0, 4'h0};
            load_done <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                cnt[i] <= load_req[i] ? cnt[i] + 4'h1 : 4'h0;
                load_done[i] <= load_req[i] && (cnt[i] >= lat);
            end
        end
    end
endmodule : sms_host_model

//--- verif/sms_startup_bench.sv
// Self-checking bench for the start sequencer
`timescale 1ns/1ps
`include "sms_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module sms_startup_bench;
    localparam logic [31:0] RTC = 32'h01000000;
    localparam logic [1:0] CM [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h0};
    localparam logic [31:0] CW [6] = '{32'h0, 32'hE10, 32'h0, 32'h0, 32'h64, 32'h64};
    localparam logic [31:0] CO [6] = '{32'h0, 32'hE10, 32'h15180, 32'h15181, 32'h65, 32'h15181};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] last_alive = RTC - 32'h5;
    logic [31:0] alive_stamp;
    logic [1:0] load_done;
    logic [1:0] load_req;
    logic [3:0] lat = 4'h0;
    logic [3:0] hmi_bank_select;
    sms_pkg::sms_ind_t ind;
    int n_fail = 0;
    int n_compared = 0;
    logic [31:0] rd;
    logic [3:0] s;
    logic [1:0] m;
    logic [31:0] w;
    logic [31:0] off;

    always #5 hclk = ~hclk;

    // Short tick so the alive stamp moves within a few dozen cycles
    sms_startup #(.TICK_CYCLES(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rtc_seconds(RTC), .last_alive_seconds(last_alive), .alive_stamp(alive_stamp),
        .load_done(load_done), .load_req(load_req), .hmi_bank_select(hmi_bank_select),
        .ind(ind));
    sms_host_model host_u (.hclk(hclk), .hresetn(hresetn), .load_req(load_req), .lat(lat),
        .load_done(load_done));

    // Expected start kind as {run, clear, flash reload, host reload}; line A in use
    function automatic logic [3:0] exp_start(input logic [1:0] md, input logic [1:0] c,
        input logic [31:0] o, input logic [31:0] wn);
        logic lng;
        lng = o > 32'h15180;
        case (md)
            2'h1: exp_start = lng ? 4'hF : 4'h8;
            2'h2: exp_start = 4'hF;
            2'h0: exp_start = (o <= wn) ? 4'h8 : (lng ? 4'hF : 4'hC);
            default: exp_start = c[1] ? 4'hF : (c[0] ? 4'h8 : 4'h0);
        endcase
    endfunction : exp_start

    // One single word transfer; waits on the slave's ready in both phases
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK("hresp", 1'b0, hresp);
    endtask : ahb

    // Restart needs a fresh rising edge of the request bit
    task automatic kick(input logic [1:0] md, input logic [1:0] c);
        ahb(1'b1, `SMS_CTRL_OFS, {27'h0, c, 1'b0, md});
        ahb(1'b1, `SMS_CTRL_OFS, {27'h0, c, 1'b1, md});
    endtask : kick

    task automatic wait_run(input int lim);
        s = 4'h0;
        repeat (lim)
        begin
            @(posedge hclk);
            s = s | {ind.run_start_indication, ind.cold_init, load_req[0], load_req[1]};
            if (ind.run_start_indication === 1'b1)
                break;
        end
    endtask : wait_run

    task automatic run_chk(input logic [3:0] e);
        wait_run(60);
        `CHK("start", e, s);
        `CHK("execution_indicator", 1'b1, ind.execution_indicator);
        `CHK("cold flag", e[2], ind.cold_start_active_flag);
        `CHK("access", 1'b1, ind.access_enable);
        ahb(1'b0, `SMS_STATUS_OFS, 32'h0);
        `CHK("kind", (e == 4'hF) ? 2'h1 : ((e == 4'hC) ? 2'h2 : 2'h0), rd[7:6]);
    endtask : run_chk

    task automatic finish_test();
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // Main sequence: power-up, registers, start kinds, host mode, second reset
    initial
    begin
        void'($urandom(2991));
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        run_chk(4'h8);
        ahb(1'b0, `SMS_CTRL_OFS, 32'h0);
        `CHK("mode reset", `SMS_MODE_HOT, rd[1:0]);
        ahb(1'b0, `SMS_OFFTIME_OFS, 32'h0);
        `CHK("offtime", 32'h5, rd);
        ahb(1'b1, `SMS_WINDOW_OFS, 32'hFFF);
        ahb(1'b0, `SMS_WINDOW_OFS, 32'h0);
        `CHK("window", `SMS_WINDOW_MAX, rd[11:0]);
        ahb(1'b1, `SMS_BANK_OFS, 32'hC);
        ahb(1'b1, `SMS_BANK_OFS, 32'hD);
        ahb(1'b0, `SMS_BANK_OFS, 32'h0);
        `CHK("bank", `SMS_BANK_MAX, rd[3:0]);
        `CHK("bank pin", `SMS_BANK_MAX, hmi_bank_select);
        ahb(1'b1, 8'h14, 32'hFF);
        ahb(1'b0, 8'h14, 32'h0);
        `CHK("hole", 32'h0, rd);
        // Threshold corners first, then random modes, windows and outages
        for (int i = 0; i < 16; i++)
        begin
            m = (i < 6) ? CM[i] : 2'($urandom % 3);
            w = (i < 6) ? CW[i] : $urandom % 32'hE11;
            off = (i < 6) ? CO[i] : (($urandom % 2) ? $urandom % 32'h1C20
                : 32'h14FF0 + $urandom % 32'h3E8);
            last_alive <= RTC - off;
            lat <= 4'($urandom % 8);
            ahb(1'b1, `SMS_WINDOW_OFS, w);
            kick(m, 2'h0);
            run_chk(exp_start(m, 2'h0, off, w));
        end
        // Host mode waits refused until a command bit arrives
        kick(`SMS_MODE_HOST, 2'h0);
        wait_run(40);
        `CHK("host wait", 4'h0, s);
        `CHK("access", 1'b0, ind.access_enable);
        ahb(1'b1, `SMS_CTRL_OFS, 32'h0F);
        run_chk(4'h8);
        kick(`SMS_MODE_HOST, 2'h3);
        run_chk(4'hF);
        kick(`SMS_MODE_HOST, 2'h0);
        kick(`SMS_MODE_COLD, 2'h0);
        run_chk(4'hF);
        repeat (25) @(posedge hclk);
        `CHK("alive", RTC, alive_stamp);
        // Reset in mid-run after a day-long outage forces a full cold start
        last_alive <= RTC - 32'h15F90;
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        run_chk(4'hF);
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        finish_test();
    end
endmodule : sms_startup_bench
